//--- rtl/low_temp_time_stamp.sv
// low-temperature time stamp: threshold compare per tick, capture, flag, irq
// stamps live in the store; control, flags and bus decode live here
// assumes Avalon-MM master on ref_clk; tick and event pins are asynchronous
//
// Implementation choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module low_temp_time_stamp
  import lts_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [9:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic [11:0] temp_reading,
  input  wire logic [47:0] cal_stamp,
  input  wire logic        tick_1hz,
  input  wire logic        ext_event_pin,
  input  wire logic        sec_write_pulse,
  input  wire logic        high_event_set,
  output logic             irq_n,
  output logic             time_sync
);
  stamp_if sif ();

  // bus phase and decode
  acc_e        acc_q;
  logic [7:0]  idx;
  logic        wr_acc;
  logic        rd_block;
  logic [31:0] rdata_q;
  // software controls and flags
  logic        en_q;
  logic        ie_q;
  logic        halt_q;
  logic        ow_q;
  logic        sync_en_q;
  logic [7:0]  thresh_q;
  logic        low_flag_q;
  logic        high_flag_q;
  // pin synchronisers
  logic        tick_s1_q;
  logic        tick_s2_q;
  logic        tick_s3_q;
  logic        ev_s1_q;
  logic        ev_s2_q;
  logic        ev_s3_q;
  // event path
  logic        tick_edge;
  logic        ev_edge;
  logic        below;
  logic        qual;
  logic        pend_q;
  logic        clr_wr;
  logic        stat_wr;
  // registered outputs
  logic        irq_n_q;
  logic        sync_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  assign idx = address[9:2];

  // bus handshake: two wait cycles, one to fetch store data, one to register it
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      acc_q <= ACC_IDLE;
    end else begin
      case (acc_q)
        ACC_IDLE:  acc_q <= (read || write) ? ACC_FETCH : ACC_IDLE;
        ACC_FETCH: acc_q <= ACC_DONE;
        ACC_DONE:  acc_q <= ACC_IDLE;
        default:   acc_q <= ACC_IDLE;
      endcase
    end
  end

  // combinational so the master sees the answer in the done phase itself
  assign waitrequest = (read || write) && (acc_q != ACC_DONE);
  assign wr_acc      = write && (acc_q == ACC_DONE) && byteenable[0];
  assign clr_wr      = wr_acc && (idx == IDX_TSCTL) && writedata[TS_CLR_BIT];
  assign stat_wr     = wr_acc && (idx == IDX_STATUS);
  // held for the whole read so the host sees one consistent set
  assign rd_block    = read && (idx >= IDX_COUNT) && (idx <= IDX_YEAR);

  // control registers written by software
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      en_q     <= 1'b0;
      ie_q     <= 1'b0;
      halt_q   <= 1'b0;
      ow_q     <= 1'b0;
      thresh_q <= RST_THRESH;
    end else if (wr_acc) begin
      case (idx)
        IDX_CTRL: begin
          en_q   <= writedata[CTRL_EN_BIT];
          ie_q   <= writedata[CTRL_IE_BIT];
          halt_q <= writedata[CTRL_HALT_BIT];
        end
        IDX_TSCTL:  ow_q     <= writedata[TS_OW_BIT];
        IDX_THRESH: thresh_q <= writedata[7:0];
        default: ;
      endcase
    end
  end

  // sync enable clears itself once an external event has been taken
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync_en_q <= 1'b0;
    end else if (ev_edge && sync_en_q) begin
      sync_en_q <= 1'b0;
    end else if (wr_acc && idx == IDX_EVCTL) begin
      sync_en_q <= writedata[EV_SYNC_BIT];
    end
  end

  // two-flop synchronisers; the third flop only feeds the edge detectors
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tick_s1_q <= 1'b0;
      tick_s2_q <= 1'b0;
      tick_s3_q <= 1'b0;
      ev_s1_q   <= 1'b0;
      ev_s2_q   <= 1'b0;
      ev_s3_q   <= 1'b0;
    end else begin
      tick_s1_q <= tick_1hz;
      tick_s2_q <= tick_s1_q;
      tick_s3_q <= tick_s2_q;
      ev_s1_q   <= ext_event_pin;
      ev_s2_q   <= ev_s1_q;
      ev_s3_q   <= ev_s2_q;
    end
  end

  // only real tick edges count; halt release and sync never fake one
  // a pin held high yields one event; reset level matches the idle pin
  assign tick_edge = tick_s2_q && !tick_s3_q && !halt_q;
  assign ev_edge   = ev_s2_q && !ev_s3_q;
  assign below     = temp_reading[TEMP_MSB:TEMP_LSB] < thresh_q;
  assign qual      = tick_edge && en_q && below;

  // an event held off by a stamp read or a clear waits here, not dropped
  // limitation: one slot only; two held events would merge into one
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= (pend_q || qual) && !sif.capture;
    end
  end

  assign sif.capture   = (pend_q || qual) && !rd_block && !clr_wr;
  assign sif.clear     = clr_wr;
  assign sif.overwrite = ow_q;
  assign sif.cal       = cal_stamp;
  assign sif.rd_idx    = 3'(idx - IDX_COUNT);

  // count and the six calendar bytes sit in the store
  stamp_store u_store (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .sif     (sif)
  );

  // event flags: a new event wins over a status write in the same cycle; a clear strobe holds the event off
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      low_flag_q  <= 1'b0;
      high_flag_q <= 1'b0;
    end else begin
      if (sif.capture) begin
        low_flag_q <= 1'b1;
      end else if (stat_wr || clr_wr) begin
        low_flag_q <= 1'b0;
      end
      if (high_event_set) begin
        high_flag_q <= 1'b1;
      end else if (stat_wr) begin
        high_flag_q <= 1'b0;
      end
    end
  end

  // active-low interrupt, gated by the enable
  // registered so the pin cannot glitch while flag and enable change
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= !(low_flag_q && ie_q);
    end
  end
  assign irq_n = irq_n_q;

  // one-cycle pulse tells the timekeeper to zero its hundredths
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync_q <= 1'b0;
    end else begin
      sync_q <= sec_write_pulse || (ev_edge && sync_en_q);
    end
  end
  assign time_sync = sync_q;

  // read data registered in the fetch phase; store data is ready by then
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h0000_0000;
    end else if (acc_q == ACC_FETCH) begin
      rdata_q <= 32'h0000_0000;
      case (idx)
        IDX_STATUS: begin
          rdata_q[ST_LOW_BIT]  <= low_flag_q;
          rdata_q[ST_HIGH_BIT] <= high_flag_q;
        end
        IDX_CTRL: begin
          rdata_q[CTRL_EN_BIT]   <= en_q;
          rdata_q[CTRL_IE_BIT]   <= ie_q;
          rdata_q[CTRL_HALT_BIT] <= halt_q;
        end
        IDX_TSCTL:  rdata_q[TS_OW_BIT]   <= ow_q; // clear bit stays 0
        IDX_EVCTL:  rdata_q[EV_SYNC_BIT] <= sync_en_q;
        IDX_THRESH: rdata_q[7:0]         <= thresh_q;
        default: begin
          if (rd_block) begin
            rdata_q[7:0] <= sif.rd_data;
          end
        end
      endcase
    end
  end
  assign readdata = rdata_q;

  // checks on the event path and the bus
  chk_enable_gate: assert property (!en_q |-> !qual)
    else $error("capture while disabled");
  chk_below_only: assert property (qual |->
    temp_reading[TEMP_MSB:TEMP_LSB] < thresh_q) else $error("event above threshold");
  chk_halt_quiet: assert property (halt_q |-> !tick_edge && !qual)
    else $error("tick while halted");
  chk_flag_set: assert property (sif.capture |=> low_flag_q)
    else $error("flag not set by event");
  chk_status_clear: assert property (stat_wr && !sif.capture && !high_event_set |=>
    !low_flag_q && !high_flag_q) else $error("status write kept flags");
  chk_irq_gate: assert property (low_flag_q && ie_q |=> !irq_n ##1 1'b1)
    else $error("irq not raised");
  chk_irq_masked: assert property (!ie_q |=> irq_n)
    else $error("irq without enable");
  chk_clear_reads: assert property (read && idx == IDX_TSCTL && !waitrequest |->
    !readdata[TS_CLR_BIT]) else $error("clear bit read back set");
  chk_read_block: assert property (rd_block |-> !sif.capture)
    else $error("capture during stamp read");
  chk_sync_pulse: assert property (sec_write_pulse |=> time_sync)
    else $error("seconds write gave no sync");
  chk_pend_done: assert property ($rose(pend_q) && !rd_block |=> !pend_q)
    else $error("pending event not taken");

  // events held off by a read or a clear must land once the way is clear
  chk_pend_taken: assert property (pend_q && !rd_block && !clr_wr |->
    sif.capture)
    else $error("held event not captured");
  chk_halt_capture: assert property (halt_q && !pend_q |->
    !sif.capture)
    else $error("capture while halted");

  // clear strobe empties the store and drops the flag
  chk_clear_flag: assert property (clr_wr |=>
    !low_flag_q)
    else $error("clear kept flag");
  chk_clear_empty: assert property (clr_wr |=>
    sif.all_zero)
    else $error("clear left stamps");
  chk_flag_hold: assert property (low_flag_q && !stat_wr && !clr_wr |=>
    low_flag_q)
    else $error("flag dropped on its own");
  chk_stat_high: assert property (stat_wr && !high_event_set |=>
    !high_flag_q)
    else $error("status write kept high flag");
  chk_irq_clear: assert property (!low_flag_q |=>
    irq_n)
    else $error("irq without flag");

  // software writes land at the accepting edge, reads return them
  chk_ctrl_write: assert property (wr_acc && idx == IDX_CTRL |=>
    en_q == $past(writedata[CTRL_EN_BIT]) && ie_q == $past(writedata[CTRL_IE_BIT]))
    else $error("control write lost");
  chk_thresh_write: assert property (wr_acc && idx == IDX_THRESH |=>
    thresh_q == $past(writedata[7:0]))
    else $error("threshold write lost");
  chk_thresh_read: assert property (read && idx == IDX_THRESH && !waitrequest |->
    readdata == {24'h000000, thresh_q})
    else $error("threshold read wrong");

  // time sync pulses only for a seconds write or a taken event
  chk_sync_event: assert property (ev_edge && sync_en_q |=>
    time_sync && !sync_en_q)
    else $error("event gave no sync");
  chk_sync_quiet: assert property (!sec_write_pulse && !(ev_edge && sync_en_q) |=>
    !time_sync)
    else $error("stray sync pulse");
endmodule

//--- rtl/lts_pkg.sv
// constants, encodings and register map of the low-temperature time stamp block
// assumes 8-bit registers, each on one 32-bit Avalon word (byte address = 4 x index)
// How it works
// - capture only while the enable bit is set
// - each tick compare temp[11:4] against low threshold
// - first-event mode keeps the first stamp only
// - overwrite mode always keeps latest stamp
// - count register counts every qualifying event
// - clear strobe zeroes count, stamps and flag
// - clear bit is a strobe, reads zero
// - reset zeroes every stamp register and count
// - halt stops tick, measurement and comparison
// - first event only when all seven are zero
// - qualifying event sets the low event flag
// - interrupt pin low only when enable set
// - a status write clears both event flags; a new event in the same cycle wins
// - no extra tick from halt release or sync
// - reading stamp registers blocks capture meanwhile
// - seconds write or synced event resets hundredths
package lts_pkg;
  // register indices
  localparam logic [7:0] IDX_STATUS = 8'h0D;
  localparam logic [7:0] IDX_CTRL   = 8'h12;
  localparam logic [7:0] IDX_TSCTL  = 8'h13;
  localparam logic [7:0] IDX_EVCTL  = 8'h15;
  localparam logic [7:0] IDX_THRESH = 8'h16;
  localparam logic [7:0] IDX_COUNT  = 8'h18;
  localparam logic [7:0] IDX_YEAR   = 8'h1E;
  // field positions
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_IE_BIT   = 1;
  localparam int CTRL_HALT_BIT = 2;
  localparam int TS_OW_BIT     = 0;
  localparam int TS_CLR_BIT    = 1;
  localparam int ST_LOW_BIT    = 0;
  localparam int ST_HIGH_BIT   = 1;
  localparam int EV_SYNC_BIT   = 0;
  localparam int TEMP_MSB      = 11;
  localparam int TEMP_LSB      = 4;
  // reset values and sizes
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] RST_THRESH = 8'h00;
  localparam int         STAMP_N    = 7;
  // bus access phases
  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_FETCH = 2'b01,
    ACC_DONE  = 2'b10
  } acc_e;
endpackage

//--- rtl/stamp_if.sv
// carrier between the control logic and the stamp store
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface stamp_if;
  logic             capture;
  logic             clear;
  logic             overwrite;
  logic [5:0][7:0]  cal;
  logic [2:0]       rd_idx;
  logic [7:0]       rd_data;
  logic             all_zero;
  modport ctl (output capture, clear, overwrite, cal, rd_idx, input rd_data, all_zero);
  modport store (input capture, clear, overwrite, cal, rd_idx, output rd_data, all_zero);
endinterface

//--- rtl/stamp_store.sv
// count and six calendar stamp bytes with registered read port
// assumes capture and clear are never high together
`timescale 1ns/1ps
module stamp_store
  import lts_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  stamp_if.store   sif
);
  logic [7:0] ent_q [STAMP_N];
  logic       zero;
  logic [7:0] rd_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // entry 0 counts, entries 1..6 follow the calendar
  for (genvar i = 0; i < STAMP_N; i++) begin : g_ent
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        ent_q[i] <= RST_BYTE;
      end else if (sif.clear) begin
        ent_q[i] <= RST_BYTE;
      end else if (sif.capture) begin
        if (i == 0) begin
          ent_q[i] <= ent_q[i] + 8'h01; // wraps at 255
        end else if (sif.overwrite || zero) begin
          ent_q[i] <= sif.cal[(i + 5) % 6]; // entry 1 takes seconds, byte 0
        end
      end
    end
  end

  // first-event test looks at all seven bytes, count included
  always_comb begin
    zero = 1'b1;
    for (int k = 0; k < STAMP_N; k++) begin
      zero = zero & (ent_q[k] == RST_BYTE);
    end
  end
  assign sif.all_zero = zero;

  // registered read port
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_q <= RST_BYTE;
    end else if (32'(sif.rd_idx) < STAMP_N) begin
      rd_q <= ent_q[sif.rd_idx];
    end else begin
      rd_q <= RST_BYTE;
    end
  end
  assign sif.rd_data = rd_q;

  chk_first_kept: assert property (sif.capture && !sif.overwrite && !zero |=>
    ent_q[1] == $past(ent_q[1])) else $error("first stamp was overwritten");
  chk_latest_kept: assert property (sif.capture && sif.overwrite |=>
    ent_q[1] == $past(sif.cal[0])) else $error("stamp not overwritten");
  chk_count_step: assert property (sif.capture |=>
    ent_q[0] == 8'($past(ent_q[0]) + 8'h01)) else $error("count did not step");
  chk_clear_zero: assert property (sif.clear |=> zero ##1 ent_q[0] != 8'hFF)
    else $error("clear left stamp data");
endmodule

//--- tb/tb.sv
// testbench for the low-temperature time stamp block
// assumes the Avalon slave answers after two wait cycles, as handed over
`timescale 1ns/1ps
module tb
  import lts_pkg::*;
;
  typedef struct {
    logic [11:0] temp;
    logic [7:0]  thr;
    logic [7:0]  ctrl;
    logic [7:0]  ts;
    logic [7:0]  cnt;
    logic [7:0]  sec;
    logic        irq_n;
  } row_s;
  logic        ref_clk, rstn, read, write, tick_1hz, ext_event_pin, wait_seen;
  logic        sec_write_pulse, high_event_set, irq_n, time_sync, waitrequest, irq_seen;
  logic [9:0]  address;
  logic [3:0]  byteenable;
  logic [31:0] writedata, readdata, rd_seen, rv;
  logic [11:0] temp_reading;
  logic [47:0] cal_stamp;
  int          errors, check_count;
  row_s        rows[6];

  low_temp_time_stamp u_low_temp_time_stamp (.ref_clk, .rstn, .address, .read, .write,
    .byteenable, .writedata, .readdata, .waitrequest, .temp_reading, .cal_stamp, .tick_1hz,
    .ext_event_pin, .sec_write_pulse, .high_event_set, .irq_n, .time_sync);
  tick_source u_tick_source (.tick_1hz);

  // free-running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // sample before each rising edge, where the combinational answer has settled
  always @(negedge ref_clk) begin
    wait_seen <= waitrequest;
    rd_seen   <= readdata;
    irq_seen  <= irq_n;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one transfer, held until waitrequest is seen low; one idle cycle after
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    address   <= {idx, 2'b00};
    read      <= ~wr;
    write     <= wr;
    writedata <= {24'h000000, wd};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wait_seen !== 1'b0 && n < 20);
    if (n >= 20) begin
      errors++; // timeout counts as a mismatch; the verdict reports it
    end
    rv = rd_seen;
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string msg);
    xfer(1'b0, idx, 8'h00);
    check(rv, exp, msg);
  endtask

  // fixed settle after the burst: capture lands three cycles after a rise
  task automatic ticks(input int n);
    u_tick_source.burst(n);
    repeat (8) @(posedge ref_clk);
  endtask

  initial begin
    int n;
    rstn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 10'h000;
    byteenable = 4'hF;
    writedata = 32'h0;
    temp_reading = 12'hFFF;
    cal_stamp = 48'h250615103000;
    ext_event_pin = 1'b0;
    sec_write_pulse = 1'b0;
    high_event_set = 1'b0;
    errors = 0;
    check_count = 0;
    // equal, disabled, first, first kept, overwrite, low nibble ignored
    rows = '{'{12'h100, 8'h10, 8'h01, 8'h00, 8'h00, 8'h00, 1'b1},
             '{12'h0FF, 8'h10, 8'h02, 8'h00, 8'h00, 8'h00, 1'b1},
             '{12'h0FF, 8'h10, 8'h01, 8'h00, 8'h01, 8'h12, 1'b1},
             '{12'h0FF, 8'h10, 8'h03, 8'h00, 8'h02, 8'h12, 1'b0},
             '{12'h0FF, 8'h10, 8'h03, 8'h01, 8'h03, 8'h14, 1'b0},
             '{12'h10F, 8'h11, 8'h03, 8'h01, 8'h04, 8'h15, 1'b0}};
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    // count and all six stamps start cleared
    for (int i = 0; i < STAMP_N; i++) begin
      rd(IDX_COUNT + 8'(i), 32'h0, "reset stamp");
    end
    check({31'h0, irq_seen}, 32'h1, "reset irq");
    xfer(1'b1, IDX_TSCTL, 8'h02);
    // table of single-tick cases
    foreach (rows[i]) begin
      temp_reading <= rows[i].temp;
      cal_stamp    <= {40'h2506151030, 8'h10 + 8'(i)};
      xfer(1'b1, IDX_THRESH, rows[i].thr);
      xfer(1'b1, IDX_TSCTL, rows[i].ts);
      xfer(1'b1, IDX_CTRL, rows[i].ctrl);
      ticks(1);
      rd(IDX_COUNT, {24'h0, rows[i].cnt}, "row count");
      rd(IDX_COUNT + 8'h01, {24'h0, rows[i].sec}, "row seconds");
      rd(IDX_STATUS, {31'h0, rows[i].cnt != 8'h00}, "row flag");
      check({31'h0, irq_seen}, {31'h0, rows[i].irq_n}, "row irq");
    end
    rd(IDX_YEAR, 32'h25, "year stamp");
    xfer(1'b1, IDX_CTRL, 8'h05);
    ticks(2);
    rd(IDX_COUNT, 32'h4, "halted count");
    xfer(1'b1, IDX_CTRL, 8'h01);
    ticks(3);
    rd(IDX_COUNT, 32'h7, "three ticks");
    high_event_set <= 1'b1;
    @(posedge ref_clk);
    high_event_set <= 1'b0;
    @(posedge ref_clk);
    rd(IDX_STATUS, 32'h3, "both flags");
    xfer(1'b1, IDX_STATUS, 8'hA5);
    rd(IDX_STATUS, 32'h0, "status write");
    ticks(1);
    xfer(1'b1, IDX_TSCTL, 8'h02);
    rd(IDX_TSCTL, 32'h0, "clear reads zero");
    rd(IDX_COUNT, 32'h0, "clear count");
    rd(IDX_COUNT + 8'h01, 32'h0, "clear seconds");
    rd(IDX_STATUS, 32'h0, "clear flag");
    // 256 events wrap the count; first-event stamp must stay
    ticks(256);
    rd(IDX_COUNT, 32'h0, "count wrap");
    cal_stamp <= 48'h250615103033;
    ticks(1);
    rd(IDX_COUNT + 8'h01, 32'h15, "first kept");
    // a tick that lands in a stamp read waits and is counted after it
    fork
      u_tick_source.burst(1);
      begin
        repeat (10) @(posedge ref_clk);
        rd(IDX_COUNT, 32'h1, "count during read");
      end
    join
    @(posedge ref_clk);
    rd(IDX_COUNT, 32'h2, "held event counted");
    rd(8'h3F, 32'h0, "unmapped");
    sec_write_pulse <= 1'b1;
    @(posedge ref_clk);
    sec_write_pulse <= 1'b0;
    @(negedge ref_clk);
    check({31'h0, time_sync}, 32'h1, "seconds sync");
    @(posedge ref_clk);
    xfer(1'b1, IDX_EVCTL, 8'h01);
    ext_event_pin <= 1'b1;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (time_sync !== 1'b1 && n < 10);
    check({31'h0, time_sync}, 32'h1, "event sync");
    @(posedge ref_clk);
    ext_event_pin <= 1'b0;
    rd(IDX_EVCTL, 32'h0, "sync self clear");
    rd(IDX_COUNT, 32'h2, "no extra tick");
    // second reset in mid-run
    rstn <= 1'b0;
    @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rd(IDX_COUNT, 32'h0, "rerun count");
    rd(IDX_CTRL, 32'h0, "rerun control");
    wrap_up();
  end
endmodule

//--- tb/tick_source.sv
// partner model: the 1 Hz tick pin as the sensor core drives it
// assumes the bench calls burst for a counted number of tick pulses
`timescale 1ns/1ps
module tick_source (
  output logic tick_1hz
);
  // idle low between bursts, so no stray edge reaches the sampler
  initial tick_1hz = 1'b0;
  // 80 ns per level, well over four ref_clk; odd offset keeps off the edge
  task automatic burst(input int n);
    #3;
    repeat (n) begin
      #80 tick_1hz = 1'b1;
      #80 tick_1hz = 1'b0;
    end
  endtask
endmodule
